// file: hdl/pidreg_pkg.sv
// constants and reset values of the pid regulator
package pidreg_pkg;

   localparam int CLK_NS = 32'h0000_0014;
   localparam int BEAT_MS = 32'h0000_0002;
   localparam int BEAT_CYCLES_DFLT = BEAT_MS * 32'h000F_4240 / CLK_NS;
   localparam int BLINK_PERIOD_MS = 32'h0000_03E8;
   localparam int BLINK_HALF_BEATS = BLINK_PERIOD_MS / (2 * BEAT_MS);
   // beats per 0.01 s and per 0.1 s
   localparam int CENTI_BEATS = 32'h0000_000A / BEAT_MS;
   localparam int DECI_BEATS = 32'h0000_0064 / BEAT_MS;
   // percentages are in 0.01 % steps; gains in 0.1 steps
   localparam int PCT_FULL = 32'h0000_2710;
   localparam int GAIN_UNITY = 32'h0000_03E8;
   localparam int WGT_ONE = 32'h0000_0400;
   localparam int WGT_SHIFT = 32'h0000_000A;
   localparam int FILT_FRAC = 32'h0000_0008;
   localparam int INTEG_FRAC = 32'h0000_0010;

   localparam int NCFG = 27;
   localparam logic [4:0] IDX_CTRL = 5'h00;
   localparam logic [4:0] IDX_SETPOINT = 5'h01;
   localparam logic [4:0] IDX_KP1 = 5'h02;
   localparam logic [4:0] IDX_TI1 = 5'h03;
   localparam logic [4:0] IDX_TD1 = 5'h04;
   localparam logic [4:0] IDX_KP2 = 5'h05;
   localparam logic [4:0] IDX_TI2 = 5'h06;
   localparam logic [4:0] IDX_TD2 = 5'h07;
   localparam logic [4:0] IDX_REV_CUTOFF = 5'h08;
   localparam logic [4:0] IDX_DEADBAND = 5'h09;
   localparam logic [4:0] IDX_DCLIP = 5'h0A;
   localparam logic [4:0] IDX_RAMP = 5'h0B;
   localparam logic [4:0] IDX_FB_FILT = 5'h0C;
   localparam logic [4:0] IDX_OUT_FILT = 5'h0D;
   localparam logic [4:0] IDX_SW_LOW = 5'h0E;
   localparam logic [4:0] IDX_SW_HIGH = 5'h0F;
   localparam logic [4:0] IDX_START_VAL = 5'h10;
   localparam logic [4:0] IDX_HOLD_TIME = 5'h11;
   localparam logic [4:0] IDX_FWD_SLEW = 5'h12;
   localparam logic [4:0] IDX_REV_SLEW = 5'h13;
   localparam logic [4:0] IDX_LOSS_THR = 5'h14;
   localparam logic [4:0] IDX_LOSS_TIME = 5'h15;
   localparam logic [4:0] IDX_WAKE_THR = 5'h16;
   localparam logic [4:0] IDX_WAKE_DLY = 5'h17;
   localparam logic [4:0] IDX_SLEEP_THR = 5'h18;
   localparam logic [4:0] IDX_SLEEP_DLY = 5'h19;
   localparam logic [4:0] IDX_MAXF = 5'h1A;
   localparam logic [4:0] IDX_STATUS = 5'h1B;
   localparam logic [4:0] IDX_FREQ = 5'h1C;

   localparam int CTRL_DIR = 0;
   localparam int CTRL_RUNCALC = 1;
   localparam int CTRL_SLEEPSRC = 2;
   localparam int CTRL_SEP = 4;
   localparam int CTRL_LIMSTOP = 5;
   localparam int CTRL_SEL_LSB = 8;
   localparam int STAT_FAULT = 0;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam logic [NCFG-1:0][15:0] CFG_RST = '{
      IDX_SETPOINT: 16'h1388, IDX_KP1: 16'h00C8, IDX_TI1: 16'h00C8,
      IDX_KP2: 16'h00C8, IDX_TI2: 16'h00C8, IDX_DCLIP: 16'h000A,
      IDX_SW_LOW: 16'h07D0, IDX_SW_HIGH: 16'h1F40, IDX_FWD_SLEW: 16'h0064,
      IDX_REV_SLEW: 16'h0064, IDX_WAKE_THR: 16'h0320, IDX_WAKE_DLY: 16'h000A,
      IDX_SLEEP_THR: 16'h0320, IDX_SLEEP_DLY: 16'h0258, IDX_MAXF: 16'h1388,
      default: 16'h0000};

   typedef struct packed {
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [15:0] wdata;
      logic [1:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [NCFG-1:0][15:0] cfg;
      logic [16:0] beat_cnt;
      logic run_prev;
      logic holding;
      logic [21:0] hold_cnt;
      logic signed [17:0] sp_ramp;
      logic signed [31:0] fb_filt;
      logic signed [17:0] fb_prev;
      logic signed [47:0] integ;
      logic signed [17:0] out_prev;
      logic signed [31:0] out_filt;
      logic signed [31:0] freq;
      logic [19:0] loss_cnt;
      logic fault;
      logic sleep;
      logic [21:0] sleep_cnt;
      logic [21:0] wake_cnt;
      logic [7:0] blink_cnt;
      logic blink;
   } pidreg_st_t;

endpackage

// file: hdl/pidreg_top.sv
// process pid regulator with axi4-lite configuration
// Overview of operation
// RULE1 - gain 100.0 on 100 % deviation gives maximum frequency
// RULE2 - integral: 100 % deviation for one integration time gives maximum
// RULE3 - derivative on feedback: 100 % per derivative time gives maximum
// RULE4 - reverse output magnitude clamped to the reverse cutoff
// RULE5 - deviation inside the deadband holds the output
// RULE6 - derivative part clipped to a small percentage
// RULE7 - setpoint ramps linearly; zero ramp time applies it at once
// RULE8 - feedback passes a low pass filter
// RULE9 - output frequency passes its own low pass filter
// RULE10 - selector 0 uses set one; 1 uses set two on the switch input
// RULE11 - selector 2 interpolates gains on deviation between thresholds
// RULE12 - selector 3 interpolates gains on output frequency
// RULE13 - output holds the initial value for the hold time after start
// RULE14 - 2 ms beat; forward and reverse step limits per beat
// RULE15 - separation plus pause input freezes the integrator
// RULE16 - limit-stop freezes integration while output sits at a limit
// RULE17 - nonzero threshold: feedback low too long raises loss fault
// RULE18 - control bit computes while stopped; default suspended
// RULE19 - sleep source: frequency request or pressure thresholds
// RULE20 - pressure mode wakes after feedback stays low for the wake delay
// RULE21 - pressure mode sleeps when feedback exceeds the sleep level
// RULE22 - sleeping blinks the run indicator with a 1 s period
// RULE23 - positive action raises output on low feedback; reverse lowers it
// RULE24 - sleep condition persists for the sleep delay first
// RULE25 - reset or suspension clears integrator, filters, ramp, last output
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pidreg_top
   import pidreg_pkg::*;
#(
   parameter int BEAT_CYCLES = BEAT_CYCLES_DFLT
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic run_cmd,
   input wire logic [15:0] feedback_pct,
   input wire logic gain_switch_in,
   input wire logic integral_pause_in,
   input wire logic freq_sleep_req,
   output logic signed [31:0] freq_command,
   output logic feedback_loss_fault,
   output logic sleeping,
   output logic run_indicator
);

   pidreg_st_t s_q, s_d;

   function automatic logic signed [31:0] lpf(input logic signed [31:0] y,
         input logic signed [31:0] x, input logic [15:0] tau);
      logic [35:0] den;
      den = 36'(tau) * 36'(CENTI_BEATS) + 36'h0_0000_0001;
      return 32'(36'(y) + (36'(x) - 36'(y)) / $signed(den));
   endfunction

   function automatic logic [15:0] interp(input logic [15:0] g1, input logic [15:0] g2,
         input logic [10:0] w);
      logic signed [31:0] diff;
      diff = $signed({16'h0000, g2}) - $signed({16'h0000, g1});
      return 16'($signed({16'h0000, g1}) + ((diff * $signed({21'h00_0000, w})) >>> WGT_SHIFT));
   endfunction

   function automatic logic signed [47:0] clamp(input logic signed [47:0] v,
         input logic signed [47:0] lo, input logic signed [47:0] hi);
      if (v < lo) begin
         return lo;
      end else if (v > hi) begin
         return hi;
      end
      return v;
   endfunction

   function automatic logic signed [47:0] pos(input logic [15:0] v);
      return $signed({32'h0000_0000, v});
   endfunction

   logic tick, active, wr_fire, fault_clr, at_limit, freeze, sleep_cond, wake_cond;
   logic [4:0] widx, ridx;
   logic [10:0] wgt;
   logic [15:0] kp, ti, td, wval, maxf1;
   logic [1:0] sel;
   logic signed [47:0] sp_t, fb_w, err, abse, p_term, d_term, i_new, raw, tgt, delta;
   logic signed [47:0] rev_lim, step, fpos, out_pct, tmp;
   logic signed [31:0] fbf_new, outf_new;

   always_comb begin
      s_d = s_q;
      tick = (s_q.beat_cnt == 17'h0_0000);
      s_d.beat_cnt = tick ? 17'(BEAT_CYCLES - 1) : s_q.beat_cnt - 17'h0_0001;
      s_d.run_prev = run_cmd;
      active = (run_cmd | s_q.cfg[IDX_CTRL][CTRL_RUNCALC]) & ~s_q.sleep; // RULE18
      maxf1 = (s_q.cfg[IDX_MAXF] == 16'h0000) ? 16'h0001 : s_q.cfg[IDX_MAXF];
      sel = s_q.cfg[IDX_CTRL][CTRL_SEL_LSB +: 2];

      // address and data in either order
      wr_fire = 1'b0;
      fault_clr = 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         s_d.aw_got = 1'b1;
         s_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_d.w_got = 1'b1;
         s_d.wdata = s_axi_wdata[15:0];
         s_d.wstrb = s_axi_wstrb[1:0];
      end
      if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
         wr_fire = 1'b1;
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      widx = s_q.awaddr[6:2];
      wval = s_q.cfg[widx];
      if (wr_fire) begin
         s_d.bresp = RESP_OKAY;
         if (s_q.awaddr[7] || s_q.awaddr[1:0] != 2'h0) begin
            s_d.bresp = RESP_SLVERR;
         end else if (int'(widx) < NCFG) begin
            if (s_q.wstrb[0]) begin
               wval[7:0] = s_q.wdata[7:0];
            end
            if (s_q.wstrb[1]) begin
               wval[15:8] = s_q.wdata[15:8];
            end
            s_d.cfg[widx] = wval;
         end else if (widx == IDX_STATUS) begin
            fault_clr = s_q.wstrb[0] & s_q.wdata[STAT_FAULT];
         end else if (widx != IDX_FREQ) begin
            s_d.bresp = RESP_SLVERR;
         end
      end else begin
         wval = 16'h0000;
      end
      ridx = s_axi_araddr[6:2];
      if (s_axi_arvalid && s_axi_arready) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = RESP_OKAY;
         s_d.rdata = 32'h0000_0000;
         if (s_axi_araddr[7] || s_axi_araddr[1:0] != 2'h0) begin
            s_d.rresp = RESP_SLVERR;
         end else if (int'(ridx) < NCFG) begin
            s_d.rdata = {16'h0000, s_q.cfg[ridx]};
         end else if (ridx == IDX_STATUS) begin
            s_d.rdata = {27'h000_0000, active, s_q.holding, s_q.sleep, 1'b0, s_q.fault};
         end else if (ridx == IDX_FREQ) begin
            s_d.rdata = s_q.freq;
         end else begin
            s_d.rresp = RESP_SLVERR;
         end
      end else if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end

      // hold armed by the run edge
      if (run_cmd && !s_q.run_prev) begin
         s_d.holding = (s_q.cfg[IDX_HOLD_TIME] != 16'h0000); // RULE13
         s_d.hold_cnt = 22'(s_q.cfg[IDX_HOLD_TIME]) * 22'(CENTI_BEATS);
      end else if (tick && s_q.holding) begin
         s_d.hold_cnt = s_q.hold_cnt - 22'h00_0001;
         s_d.holding = (s_q.hold_cnt > 22'h00_0001); // RULE13
      end

      // datapath, evaluated once per beat
      fbf_new = lpf(s_q.fb_filt, 32'(pos(feedback_pct) <<< FILT_FRAC),
            s_q.cfg[IDX_FB_FILT]); // RULE8
      fb_w = 48'(fbf_new >>> FILT_FRAC);
      step = (s_q.cfg[IDX_RAMP] == 16'h0000) ? 48'(PCT_FULL) :
            clamp(48'(PCT_FULL) / (pos(s_q.cfg[IDX_RAMP]) * 48'(CENTI_BEATS)),
            48'h0000_0000_0001, 48'(PCT_FULL)); // RULE7
      tmp = pos(s_q.cfg[IDX_SETPOINT]) - 48'(s_q.sp_ramp);
      sp_t = 48'(s_q.sp_ramp) + clamp(tmp, -step, step); // RULE7
      err = s_q.cfg[IDX_CTRL][CTRL_DIR] ? fb_w - sp_t : sp_t - fb_w; // RULE23
      abse = (err < 0) ? -err : err;
      fpos = (s_q.freq < 0) ? -48'(s_q.freq) : 48'(s_q.freq);
      wgt = 11'h000;
      case (sel)
         2'h1: wgt = gain_switch_in ? 11'(WGT_ONE) : 11'h000; // RULE10
         2'h2: begin
            if (abse >= pos(s_q.cfg[IDX_SW_HIGH])) begin
               wgt = 11'(WGT_ONE); // RULE11
            end else if (abse > pos(s_q.cfg[IDX_SW_LOW])) begin
               wgt = 11'(((abse - pos(s_q.cfg[IDX_SW_LOW])) <<< WGT_SHIFT) /
                     (pos(s_q.cfg[IDX_SW_HIGH]) - pos(s_q.cfg[IDX_SW_LOW]))); // RULE11
            end
         end
         2'h3: wgt = 11'(clamp((fpos <<< WGT_SHIFT) / pos(maxf1), 48'h0,
               48'(WGT_ONE))); // RULE12
         default: wgt = 11'h000; // RULE10
      endcase
      kp = interp(s_q.cfg[IDX_KP1], s_q.cfg[IDX_KP2], wgt);
      ti = interp(s_q.cfg[IDX_TI1], s_q.cfg[IDX_TI2], wgt);
      td = interp(s_q.cfg[IDX_TD1], s_q.cfg[IDX_TD2], wgt);
      if (ti == 16'h0000) begin
         ti = 16'h0001;
      end
      p_term = (err * pos(kp)) / 48'(GAIN_UNITY); // RULE1
      // derivative in feedback only, so setpoint steps give no kick
      tmp = ((fb_w - 48'(s_q.fb_prev)) * pos(td)) / 48'(BEAT_MS); // RULE3
      if (!s_q.cfg[IDX_CTRL][CTRL_DIR]) begin
         tmp = -tmp;
      end
      d_term = clamp(tmp, -pos(s_q.cfg[IDX_DCLIP]), pos(s_q.cfg[IDX_DCLIP])); // RULE6
      rev_lim = (pos(s_q.cfg[IDX_REV_CUTOFF]) * 48'(PCT_FULL)) / pos(maxf1); // RULE4
      at_limit = (48'(s_q.out_prev) >= 48'(PCT_FULL)) || (48'(s_q.out_prev) <= -rev_lim);
      freeze = (s_q.cfg[IDX_CTRL][CTRL_SEP] & integral_pause_in) // RULE15
            | (s_q.cfg[IDX_CTRL][CTRL_LIMSTOP] & at_limit) // RULE16
            | (abse < pos(s_q.cfg[IDX_DEADBAND]));
      i_new = s_q.integ;
      if (!freeze) begin
         i_new = s_q.integ + (err <<< INTEG_FRAC) / (pos(ti) * 48'(CENTI_BEATS)); // RULE2
      end
      // anti-windup: integrator kept in output range
      i_new = clamp(i_new, -(rev_lim <<< INTEG_FRAC), 48'(PCT_FULL) <<< INTEG_FRAC);
      raw = clamp(p_term + (i_new >>> INTEG_FRAC) + d_term, -rev_lim, 48'(PCT_FULL)); // RULE4
      tgt = (abse < pos(s_q.cfg[IDX_DEADBAND])) ? 48'(s_q.out_prev) : raw; // RULE5
      delta = clamp(tgt - 48'(s_q.out_prev), -pos(s_q.cfg[IDX_REV_SLEW]),
            pos(s_q.cfg[IDX_FWD_SLEW])); // RULE14
      out_pct = s_q.holding ? pos(s_q.cfg[IDX_START_VAL]) :
            48'(s_q.out_prev) + delta; // RULE13
      outf_new = lpf(s_q.out_filt, 32'(out_pct <<< FILT_FRAC), s_q.cfg[IDX_OUT_FILT]); // RULE9

      if (tick) begin
         if (active) begin
            s_d.fb_filt = fbf_new;
            s_d.fb_prev = 18'(fb_w);
            s_d.sp_ramp = 18'(sp_t);
            s_d.integ = i_new;
            s_d.out_prev = 18'(out_pct);
            s_d.out_filt = outf_new;
            s_d.freq = 32'(((48'(outf_new) >>> FILT_FRAC) * pos(maxf1)) / 48'(PCT_FULL));
         end else begin
            s_d.fb_filt = 32'h0000_0000; // RULE25
            s_d.fb_prev = 18'h0_0000;
            s_d.sp_ramp = 18'h0_0000;
            s_d.integ = 48'h0000_0000_0000;
            s_d.out_prev = 18'h0_0000;
            s_d.out_filt = 32'h0000_0000;
            s_d.freq = 32'h0000_0000;
         end
      end

      // loss needs low feedback past the detection time
      if (tick) begin
         if (active && s_q.cfg[IDX_LOSS_THR] != 16'h0000 &&
               feedback_pct < s_q.cfg[IDX_LOSS_THR]) begin
            if (s_q.loss_cnt != 20'hF_FFFF) begin
               s_d.loss_cnt = s_q.loss_cnt + 20'h0_0001;
            end
         end else begin
            s_d.loss_cnt = 20'h0_0000;
         end
      end
      // a loss event beats a clear in the same cycle
      s_d.fault = (s_q.fault & ~fault_clr) | (tick && s_q.loss_cnt >
            20'(s_q.cfg[IDX_LOSS_TIME]) * 20'(DECI_BEATS) && s_q.cfg[IDX_LOSS_THR] != 16'h0000); // RULE17

      // levels are per mille of the setpoint
      sleep_cond = pos(feedback_pct) * 48'h0000_0000_03E8 >
            pos(s_q.cfg[IDX_SLEEP_THR]) * pos(s_q.cfg[IDX_SETPOINT]); // RULE21
      wake_cond = pos(feedback_pct) * 48'h0000_0000_03E8 <
            pos(s_q.cfg[IDX_WAKE_THR]) * pos(s_q.cfg[IDX_SETPOINT]); // RULE20
      if (!s_q.cfg[IDX_CTRL][CTRL_SLEEPSRC]) begin
         s_d.sleep = freq_sleep_req; // RULE19
         s_d.sleep_cnt = 22'h00_0000;
         s_d.wake_cnt = 22'h00_0000;
      end else if (tick) begin
         if (!s_q.sleep) begin
            s_d.wake_cnt = 22'h00_0000;
            s_d.sleep_cnt = sleep_cond ? s_q.sleep_cnt + 22'h00_0001 : 22'h00_0000;
            if (sleep_cond && s_q.sleep_cnt >= 22'(s_q.cfg[IDX_SLEEP_DLY]) * 22'(DECI_BEATS)) begin
               s_d.sleep = 1'b1; // RULE24
            end
         end else begin
            s_d.sleep_cnt = 22'h00_0000;
            s_d.wake_cnt = wake_cond ? s_q.wake_cnt + 22'h00_0001 : 22'h00_0000;
            if (wake_cond && s_q.wake_cnt >= 22'(s_q.cfg[IDX_WAKE_DLY]) * 22'(DECI_BEATS)) begin
               s_d.sleep = 1'b0; // RULE20
            end
         end
      end

      // toggles each half period asleep
      if (!s_q.sleep) begin
         s_d.blink_cnt = 8'h00;
         s_d.blink = 1'b0;
      end else if (tick) begin
         if (s_q.blink_cnt == 8'(BLINK_HALF_BEATS - 1)) begin
            s_d.blink_cnt = 8'h00;
            s_d.blink = ~s_q.blink; // RULE22
         end else begin
            s_d.blink_cnt = s_q.blink_cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0; // RULE25
         s_q.cfg <= CFG_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign s_axi_awready = ~s_q.aw_got & ~s_q.bvalid;
   assign s_axi_wready = ~s_q.w_got & ~s_q.bvalid;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = ~s_q.rvalid;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;
   assign freq_command = s_q.freq;
   assign feedback_loss_fault = s_q.fault;
   assign sleeping = s_q.sleep;
   assign run_indicator = s_q.sleep ? s_q.blink : run_cmd; // RULE22

endmodule
`default_nettype wire

// file: dv/pidreg_sva.sv
// port checker of the pid regulator
`timescale 1ns/1ps
`default_nettype none
module pidreg_sva
   import pidreg_pkg::*;
#(
   parameter int BEAT_CYCLES = 10
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic run_cmd,
   input wire logic signed [31:0] freq_command,
   input wire logic feedback_loss_fault,
   input wire logic sleeping,
   input wire logic run_indicator
);
   localparam int BLINK_MAX = (BLINK_HALF_BEATS + 1) * BEAT_CYCLES;
   logic wr_hs, ri_q;
   logic [15:0] cut_q;
   logic [2:0] clr_q;
   int blink_q;
   assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   // copies may lead the design by a cycle
   always_ff @(posedge aclk) begin
      ri_q <= run_indicator;
      blink_q <= (!sleeping || run_indicator != ri_q) ? 0 : blink_q + 1;
      if (!aresetn) begin
         cut_q <= 16'h0000;
         clr_q <= 3'h0;
      end else if (wr_hs && s_axi_awaddr == 8'h20) begin
         cut_q <= s_axi_wdata[15:0];
      end else if (wr_hs && s_axi_awaddr == 8'h6C && s_axi_wdata[0]) begin
         clr_q <= 3'h5;
      end else if (clr_q != 3'h0) begin
         clr_q <= clr_q - 3'h1;
      end
   end
   default clocking cb @(posedge aclk);
   endclocking
   reset_clear_a: assert property (
      !aresetn |=> freq_command == '0 && !sleeping && !feedback_loss_fault)
      else $error("outputs not cleared by reset");
   indicator_follow_a: assert property (
      disable iff (!aresetn) !sleeping |-> run_indicator == run_cmd)
      else $error("indicator not run while awake");
   blink_half_a: assert property (
      disable iff (!aresetn) blink_q <= BLINK_MAX)
      else $error("blink too slow");
   beat_step_a: assert property (
      disable iff (!aresetn) $changed(freq_command) |=> $stable(freq_command) [*8])
      else $error("freq moved between beats");
   rev_cutoff_a: assert property (
      disable iff (!aresetn) freq_command >= -$signed({16'h0000, cut_q}))
      else $error("reverse beyond cutoff");
   upper_limit_a: assert property (
      disable iff (!aresetn) freq_command <= $signed({16'h0000, CFG_RST[IDX_MAXF]}))
      else $error("freq above maximum");
   sleep_zero_a: assert property (
      disable iff (!aresetn) $rose(sleeping) |-> ##[0:12] freq_command == '0)
      else $error("freq not cleared on sleep");
   fault_sticky_a: assert property (
      disable iff (!aresetn) feedback_loss_fault && clr_q == 3'h0 && !wr_hs
      |=> feedback_loss_fault) else $error("fault dropped without clear");
   cover property (disable iff (!aresetn) $rose(sleeping));
   cover property (disable iff (!aresetn) $rose(feedback_loss_fault));
   cover property (disable iff (!aresetn) freq_command < 0);
endmodule
bind pidreg_top pidreg_sva #(.BEAT_CYCLES(BEAT_CYCLES)) sva_u (.aclk, .aresetn,
   .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
   .s_axi_wready, .run_cmd, .freq_command, .feedback_loss_fault, .sleeping, .run_indicator);
`default_nettype wire

// file: dv/pidreg_far.sv
// feedback sensor model slewing to a target
`timescale 1ns/1ps
`default_nettype none
module pidreg_far (
   input wire logic aclk,
   input wire logic [15:0] target_pct,
   input wire logic [15:0] step_pct,
   output logic [15:0] feedback_pct
);
   // step 0 is ideal; otherwise the reading lags
   initial feedback_pct = 16'h0000;
   always @(posedge aclk) begin
      if (step_pct != 16'h0000 && feedback_pct + step_pct < target_pct) begin
         feedback_pct <= feedback_pct + step_pct;
      end else if (step_pct != 16'h0000 && feedback_pct > target_pct + step_pct) begin
         feedback_pct <= feedback_pct - step_pct;
      end else begin
         feedback_pct <= target_pct;
      end
   end
endmodule
`default_nettype wire

// file: dv/test_process_pid_regulator.sv
// self-checking bench of the pid regulator
`timescale 1ns/1ps
`default_nettype none
module test_process_pid_regulator;
   import pidreg_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b1, s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, run_cmd = 1'b0;
   logic gain_switch_in = 1'b0, integral_pause_in = 1'b0, freq_sleep_req = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [15:0] fb_target = 16'h0000, fb_step = 16'h0000, feedback_pct;
   logic s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
   logic feedback_loss_fault, sleeping, run_indicator;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp_q;
   logic [31:0] s_axi_rdata, rd_q;
   logic signed [31:0] freq_command;
   int n_mismatch = 0, comparisons = 0;
   pidreg_far far_u (.aclk, .target_pct(fb_target), .step_pct(fb_step), .feedback_pct);
   pidreg_top #(.BEAT_CYCLES(10)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .run_cmd,
      .feedback_pct, .gain_switch_in, .integral_pause_in, .freq_sleep_req, .freq_command,
      .feedback_loss_fault, .sleeping, .run_indicator);
   task automatic report_and_stop;
      $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic give_up;
      n_mismatch++;
      report_and_stop();
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] ad(input logic [4:0] i);
      return {1'b0, i, 2'b00};
   endfunction
   task automatic wr(input logic [4:0] idx, input logic [15:0] d);
      int n;
      s_axi_awaddr <= ad(idx);
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      if (n == 50) give_up();
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      rd_q = s_axi_rdata;
      resp_q = s_axi_rresp;
      if (n == 50) give_up();
   endtask
   task automatic steps(input int d, input int k);
      logic signed [31:0] prev;
      int n;
      repeat (k) begin
         prev = freq_command;
         for (n = 0; n < 40 && freq_command === prev; n++) @(posedge aclk);
         if (n == 40) give_up();
         chk(freq_command - prev, d);
      end
   endtask
   task automatic settle(ref logic s, input logic v, input int lo, input int hi);
      int n;
      for (n = 0; n < hi && s !== v; n++) @(posedge aclk);
      if (n == hi) give_up();
      chk(32'(n >= lo), 1);
   endtask
   task automatic t_regs;
      rd(ad(IDX_CTRL));
      chk(rd_q, 32'h0000_0000);
      rd(ad(IDX_DCLIP));
      chk(rd_q, 32'h0000_000A);
      rd(ad(IDX_FWD_SLEW));
      chk(rd_q, 32'h0000_0064);
      rd(8'h74);
      chk(32'(resp_q), 32'(RESP_SLVERR));
   endtask
   task automatic t_slew;
      wr(IDX_CTRL, 16'h0100);
      gain_switch_in <= 1'b1;
      run_cmd <= 1'b1;
      steps(50, 4);
      run_cmd <= 1'b0;
      repeat (40) @(posedge aclk);
      chk(freq_command, 0);
      wr(IDX_REV_CUTOFF, 16'h0064);
      wr(IDX_REV_SLEW, 16'h0028);
      wr(IDX_CTRL, 16'h0101);
      run_cmd <= 1'b1;
      steps(-20, 5);
      repeat (100) @(posedge aclk);
      chk(freq_command, -100);
      run_cmd <= 1'b0;
      wr(IDX_CTRL, 16'h0000);
      repeat (40) @(posedge aclk);
   endtask
   task automatic t_hold;
      wr(IDX_START_VAL, 16'h0BB8);
      wr(IDX_HOLD_TIME, 16'h0004);
      run_cmd <= 1'b1;
      repeat (30) @(posedge aclk);
      chk(freq_command, 1500);
      repeat (120) @(posedge aclk);
      chk(freq_command, 1500);
      repeat (150) @(posedge aclk);
      chk(32'(freq_command != 1500), 1);
      run_cmd <= 1'b0;
      wr(IDX_HOLD_TIME, 16'h0000);
      repeat (40) @(posedge aclk);
   endtask
   task automatic t_dead;
      wr(IDX_DEADBAND, 16'h00C8);
      wr(IDX_CTRL, 16'h0010);
      integral_pause_in <= 1'b1;
      fb_target <= 16'h1324;
      repeat (20) @(posedge aclk);
      run_cmd <= 1'b1;
      repeat (200) @(posedge aclk);
      chk(freq_command, 0);
      wr(IDX_DEADBAND, 16'h0000);
      repeat (200) @(posedge aclk);
      chk(freq_command, 10);
      integral_pause_in <= 1'b0;
      repeat (1000) @(posedge aclk);
      chk(32'(freq_command > 10), 1);
      run_cmd <= 1'b0;
   endtask
   task automatic t_loss;
      wr(IDX_CTRL, 16'h0000);
      wr(IDX_LOSS_THR, 16'h01F4);
      wr(IDX_LOSS_TIME, 16'h0001);
      fb_step <= 16'h0400;
      fb_target <= 16'h0000;
      run_cmd <= 1'b1;
      settle(feedback_loss_fault, 1'b1, 450, 700);
      rd(ad(IDX_STATUS));
      chk(32'(rd_q[0]), 1);
      fb_target <= 16'h03E8;
      repeat (20) @(posedge aclk);
      wr(IDX_STATUS, 16'h0001);
      repeat (3) @(posedge aclk);
      chk(32'(feedback_loss_fault), 0);
      wr(IDX_LOSS_THR, 16'h0000);
   endtask
   task automatic t_sleep;
      wr(IDX_SLEEP_DLY, 16'h0001);
      wr(IDX_WAKE_DLY, 16'h0001);
      wr(IDX_CTRL, 16'h0004);
      fb_target <= 16'h1194;
      settle(sleeping, 1'b1, 450, 700);
      settle(run_indicator, ~run_indicator, 0, 2600);
      settle(run_indicator, ~run_indicator, 0, 2600);
      settle(run_indicator, ~run_indicator, 2490, 2520);
      fb_target <= 16'h03E8;
      settle(sleeping, 1'b0, 450, 700);
      wr(IDX_CTRL, 16'h0000);
      freq_sleep_req <= 1'b1;
      settle(sleeping, 1'b1, 0, 20);
      freq_sleep_req <= 1'b0;
      settle(sleeping, 1'b0, 0, 20);
   endtask
   initial begin
      forever #10 aclk = ~aclk;
   end
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs();
      t_slew();
      t_hold();
      t_dead();
      t_loss();
      t_sleep();
      report_and_stop();
   end
endmodule
`default_nettype wire
